// file: hw/temp_limit_pkg.sv
// shared constants and carriers for the conversion scheduler and limit checker
package temp_limit_pkg;
   // register addresses
   localparam logic [7:0] ADDR_LOCAL_VALUE = 8'h00;
   localparam logic [7:0] ADDR_R1_VALUE_HI = 8'h01;
   localparam logic [7:0] ADDR_STATUS1 = 8'h02;
   localparam logic [7:0] ADDR_CONFIG1_RD = 8'h03;
   localparam logic [7:0] ADDR_RATE_RD = 8'h04;
   localparam logic [7:0] ADDR_CONFIG1_WR = 8'h09;
   localparam logic [7:0] ADDR_RATE_WR = 8'h0a;
   localparam logic [7:0] ADDR_R1_VALUE_LO = 8'h10;
   localparam logic [7:0] ADDR_HYST = 8'h21;
   localparam logic [7:0] ADDR_STATUS2 = 8'h23;
   localparam logic [7:0] ADDR_R2_VALUE_HI = 8'h30;
   localparam logic [7:0] ADDR_R2_VALUE_LO = 8'h33;
   // limit blocks: base + channel (0 local, 1 remote one, 2 remote two)
   localparam logic [7:0] ADDR_HIGH_HI_BASE = 8'h40;
   localparam logic [7:0] ADDR_HIGH_LO_BASE = 8'h44;
   localparam logic [7:0] ADDR_LOW_HI_BASE = 8'h48;
   localparam logic [7:0] ADDR_LOW_LO_BASE = 8'h4c;
   localparam logic [7:0] ADDR_OVERTEMP_OUT_N_BASE = 8'h50;
   localparam logic [7:0] ADDR_BLOCK_MASK = 8'hfc;
   // reset values
   localparam logic [7:0] RATE_RESET = 8'h08;
   localparam logic [7:0] CONFIG1_RESET = 8'h00;
   localparam logic [7:0] HYST_RESET = 8'h0a;
   localparam logic [7:0] HIGH_LIMIT_RESET = 8'h55;
   localparam logic [7:0] LOW_LIMIT_RESET = 8'h00;
   localparam logic [7:0] OVERTEMP_OUT_N_LIMIT_RESET = 8'h55;
   // field positions
   localparam int RATE_AVG_DIS_BIT = 7;
   localparam int RATE_RSVD_BIT = 6;
   localparam int RATE_SEL_LSB = 4;
   localparam int CFG_PIN_FUNC_BIT = 5;
   localparam int CFG_RANGE_BIT = 2;
   localparam logic [7:0] RATE_WRITE_MASK = 8'hbf;
   localparam logic [3:0] RATE_CONTINUOUS = 4'hb;
   localparam logic [3:0] RATE_FASTEST = 4'ha;
   localparam logic [3:0] RATE_FIRST_NO_AVG = 4'h8;
   localparam logic [1:0] SEL_ROUND_ROBIN = 2'b00;
   localparam logic [1:0] CH_LOCAL = 2'd0;
   localparam logic [1:0] CH_LAST = 2'd2;
   localparam int NUM_CH = 3;
   // timing
   localparam longint unsigned CLOCK_KHZ = 250000;
   localparam longint unsigned BASE_INTERVAL_MS = 16000;
   localparam longint unsigned FASTEST_INTERVAL_US = 15500;
   localparam longint unsigned BASE_INTERVAL_CYC = BASE_INTERVAL_MS * CLOCK_KHZ;
   localparam longint unsigned FASTEST_INTERVAL_CYC = FASTEST_INTERVAL_US * CLOCK_KHZ / 1000;

   typedef struct packed {
      logic start;
      logic [1:0] chan;
   } conv_req_s;

   typedef struct packed {
      logic valid;
      logic [1:0] chan;
      logic [9:0] value;
   } conv_result_s;

   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_REQ = 3'b010,
      S_WAIT = 3'b100
   } sched_state_e;
endpackage

// file: hw/temp_conversion_limit_control.sv
// conversion scheduling, register file and limit comparison of the temperature monitor
//
// Functional notes
// [R01] rate register read 0x04, written 0x0A
// [R02] low nibble picks interval, halving each step
// [R03] code 0x0B converts back to back
// [R04] each interval converts every enabled channel once
// [R05] rate register resets to 0x08
// [R06] bit 7 disables averaging at slow rates
// [R07] host leaves reserved bit 6 alone
// [R08] bits 5:4 pick round robin or one channel
// [R09] high, low, overtemp limit per channel
// [R10] limits and hysteresis read and writable
// [R11] high flag when value above high limit
// [R12] low flag when value at or below low
// [R13] overtemp output low above overtemp limit
// [R14] second output low above high limit
// [R15] one hysteresis, reset 10, for both outputs
// [R16] limits compared raw, kept across format change
// [R17] host rewrites limits after format change
// [R18] extended range uses offset binary plus 64
// [R19] config bit 5 selects shared pin function
// [R20] outputs release below limit minus hysteresis
// [R21] high and low flags sticky until status read
// [R22] unconverted channels keep results, no checks
// [R23] rate change applies at next interval
`timescale 1ns/1ps
module temp_conversion_limit_control
   import temp_limit_pkg::*;
#(
   parameter logic [31:0] BASE_CYCLES = 32'(BASE_INTERVAL_CYC),
   parameter logic [31:0] FASTEST_CYCLES = 32'(FASTEST_INTERVAL_CYC)
)(
   input wire logic clock, // 250 MHz
   input wire logic sys_rst, // synchronous, active high
   input wire logic [7:0] regAddr, // register address from the serial interface
   input wire logic regWrite, // write strobe
   input wire logic [7:0] regWdata, // write data
   input wire logic regRead, // read strobe, a status read clears sticky flags
   output logic [7:0] regRdata, // read data, valid the cycle after regRead
   output conv_req_s convReq, // conversion request to the converter
   input wire conv_result_s convResult, // converter result
   output logic avgEnable, // averaging on for this conversion
   output logic rangeExtended, // offset binary format selected
   output logic busy, // a conversion cycle is running
   output logic overtemp_out_n, // overtemp output, active low
   output logic second_overtemp_out_n // shared pin: alarm or second overtemp, active low
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] rateReg;
   logic [7:0] config1;
   logic [7:0] hyst;
   logic [7:0] highHi [NUM_CH];
   logic [7:0] highLo [NUM_CH];
   logic [7:0] lowHi [NUM_CH];
   logic [7:0] lowLo [NUM_CH];
   logic [7:0] thermLim [NUM_CH];
   logic [9:0] result [NUM_CH];
   logic [NUM_CH-1:0] highFlag, lowFlag, thermAct, therm2Act;
   sched_state_e state;
   logic [31:0] waitCount;
   logic [3:0] activeRate;
   logic [1:0] activeSel;
   logic [1:0] curChan;

   // interval length in cycles for a rate code
   function automatic logic [31:0] intervalOf(input logic [3:0] code);
      if (code == RATE_CONTINUOUS) return 32'd0; // [R03]
      if (code == RATE_FASTEST) return FASTEST_CYCLES; // [R02]
      return BASE_CYCLES >> code; // [R02]
   endfunction

   function automatic logic [9:0] limit10(input logic [7:0] hi, input logic [7:0] lo);
      return {hi, lo[7:6]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // register decode
   wire logic [1:0] blockCh = regAddr[1:0];
   wire logic chOk = blockCh <= CH_LAST;
   wire logic [7:0] blockAddr = regAddr & ADDR_BLOCK_MASK;
   wire logic wrRate = regWrite && regAddr == ADDR_RATE_WR; // [R01]
   wire logic wrCfg = regWrite && regAddr == ADDR_CONFIG1_WR;
   wire logic wrHyst = regWrite && regAddr == ADDR_HYST; // [R10]
   wire logic wrHighHi = regWrite && chOk && blockAddr == ADDR_HIGH_HI_BASE;
   wire logic wrHighLo = regWrite && chOk && blockCh != CH_LOCAL && blockAddr == ADDR_HIGH_LO_BASE;
   wire logic wrLowHi = regWrite && chOk && blockAddr == ADDR_LOW_HI_BASE;
   wire logic wrLowLo = regWrite && chOk && blockCh != CH_LOCAL && blockAddr == ADDR_LOW_LO_BASE;
   wire logic wrTherm = regWrite && chOk && blockAddr == ADDR_OVERTEMP_OUT_N_BASE;
   wire logic rdStatus1 = regRead && regAddr == ADDR_STATUS1;
   wire logic rdStatus2 = regRead && regAddr == ADDR_STATUS2;
   wire logic alarmMode = !config1[CFG_PIN_FUNC_BIT]; // [R19]

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         rateReg <= RATE_RESET; // [R05]
         config1 <= CONFIG1_RESET;
         hyst <= HYST_RESET; // [R15]
         for (int i = 0; i < NUM_CH; i++)
         begin
            highHi[i] <= HIGH_LIMIT_RESET;
            highLo[i] <= 8'h00;
            lowHi[i] <= LOW_LIMIT_RESET;
            lowLo[i] <= 8'h00;
            thermLim[i] <= OVERTEMP_OUT_N_LIMIT_RESET;
         end
      end
      else
      begin
         if (wrRate) rateReg <= regWdata & RATE_WRITE_MASK; // [R07]
         if (wrCfg) config1 <= regWdata; // [R16]
         if (wrHyst) hyst <= regWdata; // [R15]
         if (wrHighHi) highHi[blockCh] <= regWdata; // [R09]
         if (wrHighLo) highLo[blockCh] <= regWdata; // [R09]
         if (wrLowHi) lowHi[blockCh] <= regWdata; // [R09]
         if (wrLowLo) lowLo[blockCh] <= regWdata; // [R09]
         if (wrTherm) thermLim[blockCh] <= regWdata; // [R09]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   wire logic [7:0] status1 = {busy, highFlag[0], lowFlag[0], highFlag[1], lowFlag[1],
      1'b0, thermAct[1], thermAct[0]};
   wire logic [7:0] status2 = {3'b000, highFlag[2], lowFlag[2], 1'b0, thermAct[2],
      alarmMode && (|highFlag || |lowFlag)};
   logic [7:0] readMux;
   always_comb
   begin
      readMux = 8'h00;
      if (regAddr == ADDR_LOCAL_VALUE) readMux = result[0][9:2];
      else if (regAddr == ADDR_R1_VALUE_HI) readMux = result[1][9:2];
      else if (regAddr == ADDR_R1_VALUE_LO) readMux = {result[1][1:0], 6'h00};
      else if (regAddr == ADDR_R2_VALUE_HI) readMux = result[2][9:2];
      else if (regAddr == ADDR_R2_VALUE_LO) readMux = {result[2][1:0], 6'h00};
      else if (regAddr == ADDR_STATUS1) readMux = status1;
      else if (regAddr == ADDR_STATUS2) readMux = status2;
      else if (regAddr == ADDR_CONFIG1_RD) readMux = config1;
      else if (regAddr == ADDR_RATE_RD) readMux = rateReg; // [R01]
      else if (regAddr == ADDR_HYST) readMux = hyst; // [R10]
      else if (chOk && blockAddr == ADDR_HIGH_HI_BASE) readMux = highHi[blockCh]; // [R10]
      else if (chOk && blockAddr == ADDR_HIGH_LO_BASE) readMux = highLo[blockCh];
      else if (chOk && blockAddr == ADDR_LOW_HI_BASE) readMux = lowHi[blockCh];
      else if (chOk && blockAddr == ADDR_LOW_LO_BASE) readMux = lowLo[blockCh];
      else if (chOk && blockAddr == ADDR_OVERTEMP_OUT_N_BASE) readMux = thermLim[blockCh];
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst) regRdata <= 8'h00;
      else if (regRead) regRdata <= readMux;
   end

   ////////////////////////////////////////////////////////////////////////////
   // conversion scheduler
   wire logic singleSel = activeSel != SEL_ROUND_ROBIN;
   // the cycle about to start follows the register, not the latched selection
   wire logic [1:0] reqSel = rateReg[RATE_SEL_LSB +: 2];
   wire logic [1:0] firstChan = (reqSel != SEL_ROUND_ROBIN) ? 2'(reqSel - 2'd1) : CH_LOCAL;
   wire logic resultHere = state == S_WAIT && convResult.valid && convResult.chan == curChan;
   wire logic lastChan = singleSel || curChan == CH_LAST; // [R08]

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         state <= S_IDLE;
         waitCount <= 32'd0;
         activeRate <= RATE_RESET[3:0];
         activeSel <= SEL_ROUND_ROBIN;
         curChan <= CH_LOCAL;
      end
      else
      begin
         unique case (state)
            S_IDLE:
            begin
               if (waitCount == 32'd0)
               begin
                  activeRate <= rateReg[3:0]; // [R23]
                  activeSel <= rateReg[RATE_SEL_LSB +: 2]; // [R08]
                  curChan <= firstChan; // [R08]
                  state <= S_REQ; // [R04]
               end
               else waitCount <= waitCount - 32'd1;
            end
            S_REQ: state <= S_WAIT;
            S_WAIT:
            begin
               if (resultHere && lastChan)
               begin
                  // interval counted from cycle start minus time spent converting is not tracked
                  waitCount <= intervalOf(activeRate); // [R02]
                  state <= S_IDLE;
               end
               else if (resultHere)
               begin
                  curChan <= 2'(curChan + 2'd1); // [R04]
                  state <= S_REQ;
               end
            end
         endcase
      end
   end

   assign convReq.start = state == S_REQ;
   assign convReq.chan = curChan;
   assign busy = state != S_IDLE;
   assign avgEnable = !rateReg[RATE_AVG_DIS_BIT] &&
      (activeRate < RATE_FIRST_NO_AVG || activeRate == RATE_CONTINUOUS); // [R06]
   assign rangeExtended = config1[CFG_RANGE_BIT]; // [R18]

   ////////////////////////////////////////////////////////////////////////////
   // limit checks on each fresh result
   wire logic [10:0] hyst10 = {1'b0, hyst, 2'b00};
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         highFlag <= '0;
         lowFlag <= '0;
         thermAct <= '0;
         therm2Act <= '0;
         for (int i = 0; i < NUM_CH; i++) result[i] <= 10'h000;
      end
      else
      begin
         for (int i = 0; i < NUM_CH; i++)
         begin
            automatic logic hit = resultHere && curChan == 2'(i); // [R22]
            automatic logic [9:0] v = convResult.value;
            automatic logic [9:0] hiL = (i == 0) ? {highHi[i], 2'b00} :
               limit10(highHi[i], highLo[i]);
            automatic logic [9:0] loL = (i == 0) ? {lowHi[i], 2'b00} :
               limit10(lowHi[i], lowLo[i]);
            automatic logic [9:0] thL = {thermLim[i], 2'b00};
            automatic logic clr1 = (i < 2) ? rdStatus1 : rdStatus2;
            if (hit) result[i] <= v; // [R22]
            // set wins over a clearing read
            if (hit && v > hiL) highFlag[i] <= 1'b1; // [R11]
            else if (clr1) highFlag[i] <= 1'b0; // [R21]
            if (hit && v <= loL) lowFlag[i] <= 1'b1; // [R12]
            else if (clr1) lowFlag[i] <= 1'b0; // [R21]
            if (hit && v > thL) thermAct[i] <= 1'b1; // [R13]
            else if (hit && ({1'b0, v} + hyst10) < {1'b0, thL}) thermAct[i] <= 1'b0; // [R20]
            if (hit && v > hiL) therm2Act[i] <= 1'b1; // [R14]
            else if (hit && ({1'b0, v} + hyst10) < {1'b0, hiL}) therm2Act[i] <= 1'b0; // [R20]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drive
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         overtemp_out_n <= 1'b1;
         second_overtemp_out_n <= 1'b1;
      end
      else
      begin
         overtemp_out_n <= !(|thermAct); // [R13]
         second_overtemp_out_n <= alarmMode ? !(|highFlag || |lowFlag) : !(|therm2Act); // [R14]
      end
   end
endmodule // temp_conversion_limit_control

// file: dv/temp_conversion_limit_control_monitor.sv
// port assertions for the conversion scheduler and limit checker
`timescale 1ns/1ps
module temp_conversion_limit_control_monitor
   import temp_limit_pkg::*;
#(
   parameter logic [31:0] BASE_CYCLES = 32'(BASE_INTERVAL_CYC),
   parameter logic [31:0] FASTEST_CYCLES = 32'(FASTEST_INTERVAL_CYC)
)(
   input wire logic clock, // clock
   input wire logic sys_rst, // reset
   input wire logic [7:0] regAddr, // address
   input wire logic regWrite, // write strobe
   input wire logic [7:0] regWdata, // write data
   input wire logic regRead, // read strobe
   input wire logic [7:0] regRdata, // read data
   input wire conv_req_s convReq, // request
   input wire conv_result_s convResult, // result
   input wire logic avgEnable, // averaging
   input wire logic rangeExtended, // format
   input wire logic busy, // busy
   input wire logic overtemp_out_n, // overtemp pin
   input wire logic second_overtemp_out_n // shared pin
);
   logic [7:0] rateCopy;
   logic [7:0] rateQ;
   logic [3:0] activeCode;
   logic busyQ;
   // rate code in force: taken from the register as each cycle starts
   wire logic [3:0] code = (busy && !busyQ) ? rateQ[3:0] : activeCode;
   wire logic slowRate = code < RATE_FIRST_NO_AVG || code == RATE_CONTINUOUS;
   wire logic expAvg = !rateCopy[RATE_AVG_DIS_BIT] && slowRate;
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         rateCopy <= RATE_RESET;
         rateQ <= RATE_RESET;
         activeCode <= RATE_RESET[3:0];
         busyQ <= 1'b0;
      end
      else
      begin
         if (regWrite && regAddr == ADDR_RATE_WR)
            rateCopy <= regWdata & RATE_WRITE_MASK;
         rateQ <= rateCopy;
         activeCode <= code;
         busyQ <= busy;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   property p_reset; $fell(sys_rst) |-> !busy && overtemp_out_n && !avgEnable; endproperty
   a_reset: assert property (p_reset) else $error("bad state after reset");
   property p_avg; avgEnable == expAvg; endproperty
   a_avg: assert property (p_avg) else $error("averaging enable wrong");
   property p_rate_read; regRead && regAddr == ADDR_RATE_RD |=> regRdata == $past(rateCopy);
   endproperty
   a_rate_read: assert property (p_rate_read) else $error("rate readback wrong");
   property p_range; $past(regWrite && regAddr == ADDR_CONFIG1_WR)
      |-> rangeExtended == $past(regWdata[CFG_RANGE_BIT]); endproperty
   a_range: assert property (p_range) else $error("range select wrong");
   property p_start_pulse; convReq.start |=> !convReq.start; endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start too long");
   property p_cycle_start; $rose(busy) |-> convReq.start && convReq.chan ==
      ($past(rateCopy[5:4]) == 2'b00 ? 2'b00 : $past(rateCopy[5:4]) - 2'd1); endproperty
   a_cycle_start: assert property (p_cycle_start) else $error("cycle start wrong");
   property p_pin_cause; $changed(overtemp_out_n)
      |-> $past(convResult.valid) || $past(convResult.valid, 2); endproperty
   a_pin_cause: assert property (p_pin_cause) else $error("pin moved without result");
   property p_rdata_hold; !$past(regRead) |-> $stable(regRdata); endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   c_remote_two: cover property (convReq.start && convReq.chan == 2'd2);
   c_overtemp: cover property ($fell(overtemp_out_n));
   c_second: cover property ($fell(second_overtemp_out_n));
endmodule // temp_conversion_limit_control_monitor
bind temp_conversion_limit_control temp_conversion_limit_control_monitor #(
   .BASE_CYCLES(BASE_CYCLES), .FASTEST_CYCLES(FASTEST_CYCLES)) u_monitor (
   .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrite(regWrite),
   .regWdata(regWdata), .regRead(regRead), .regRdata(regRdata), .convReq(convReq),
   .convResult(convResult), .avgEnable(avgEnable), .rangeExtended(rangeExtended),
   .busy(busy), .overtemp_out_n(overtemp_out_n),
   .second_overtemp_out_n(second_overtemp_out_n));

// file: dv/conv_model.sv
// behavioural converter answering each request after a set delay
`timescale 1ns/1ps
module conv_model
   import temp_limit_pkg::*;
(
   input wire logic clock, // clock
   input wire conv_req_s convReq, // request
   input wire logic [29:0] chanValues, // result per channel, channel 0 lowest
   input wire logic [3:0] answerDelay, // answer appears this many plus two cycles after the request cycle
   output conv_result_s convResult // answer
);
   int count = -1;
   logic [1:0] chan = 2'h0;
   always @(posedge clock)
   begin
      convResult.valid <= 1'b0;
      convResult.value <= ~convResult.value; // released data keeps moving
      count <= convReq.start ? int'(answerDelay) : count - 1;
      if (convReq.start)
         chan <= convReq.chan;
      if (count == 0)
         convResult <= {1'b1, chan, chanValues[10 * chan +: 10]};
   end
endmodule // conv_model

// file: dv/test_temp_conversion_limit_control.sv
// self-checking testbench of the conversion scheduler and limit checker
`timescale 1ns/1ps
module test_temp_conversion_limit_control
   import temp_limit_pkg::*;
;
   localparam logic [31:0] BASE = 32'd2048;
   localparam logic [31:0] FAST = 32'd3;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, rd;
   logic regWrite = 1'b0, regRead = 1'b0;
   logic avgEnable, rangeExtended, busy, overtemp_out_n, second_overtemp_out_n;
   conv_req_s convReq;
   conv_result_s convResult;
   logic [29:0] chanValues = {3{10'h040}};
   int mismatches = 0, num_checks = 0, cycles = 0;
   always #2 clock = ~clock;
   temp_conversion_limit_control #(.BASE_CYCLES(BASE), .FASTEST_CYCLES(FAST)) u_dut (
      .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrite(regWrite),
      .regWdata(regWdata), .regRead(regRead), .regRdata(regRdata), .convReq(convReq),
      .convResult(convResult), .avgEnable(avgEnable), .rangeExtended(rangeExtended),
      .busy(busy), .overtemp_out_n(overtemp_out_n),
      .second_overtemp_out_n(second_overtemp_out_n));
   conv_model u_model (.clock(clock), .convReq(convReq), .chanValues(chanValues),
      .answerDelay(4'h2), .convResult(convResult));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      regAddr = a;
      regWdata = d;
      regWrite = 1'b1;
      @(negedge clock);
      regWrite = 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(negedge clock);
      regAddr = a;
      regRead = 1'b1;
      @(negedge clock);
      regRead = 1'b0;
      rd = regRdata;
   endtask
   task automatic wait_cycle;
      while (busy !== 1'b1) @(negedge clock);
      while (busy !== 1'b0) @(negedge clock);
   endtask
   task automatic idle_len(input logic [3:0] code, output int n);
      wr(ADDR_RATE_WR, {4'h0, code});
      wait_cycle();
      wait_cycle();
      for (n = 0; busy !== 1'b1; n++) @(negedge clock);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_registers;
      logic [7:0] base [5] = '{ADDR_HIGH_HI_BASE, ADDR_HIGH_LO_BASE, ADDR_LOW_HI_BASE,
         ADDR_LOW_LO_BASE, ADDR_OVERTEMP_OUT_N_BASE};
      logic [7:0] dflt [5] = '{HIGH_LIMIT_RESET, 8'h00, LOW_LIMIT_RESET, 8'h00,
         OVERTEMP_OUT_N_LIMIT_RESET};
      rdr(ADDR_RATE_RD);
      check(rd, RATE_RESET);
      rdr(ADDR_HYST);
      check(rd, HYST_RESET);
      rdr(8'hff);
      check(rd, 8'h00);
      for (int b = 0; b < 5; b++)
         for (int c = 0; c < NUM_CH; c++)
         begin
            wr(base[b] + 8'(c), 8'hc0);
            rdr(base[b] + 8'(c));
            check(rd, (c == 0 && (b == 1 || b == 3)) ? 8'h00 : 8'hc0);
            wr(base[b] + 8'(c), dflt[b]);
         end
      wr(ADDR_LOW_HI_BASE + 8'h01, 8'h20);
      $display("test_registers done");
   endtask
   task automatic test_rates;
      int a, b;
      for (int k = 0; k < 24; k++)
      begin
         wr(ADDR_RATE_WR, {k >= 12, 3'b000, 4'(k % 12)});
         rdr(ADDR_RATE_RD);
         check(rd, {k >= 12, 3'b000, 4'(k % 12)});
         // the new rate code takes over at the next cycle start
         while (busy !== 1'b0) @(negedge clock);
         while (busy !== 1'b1) @(negedge clock);
         check(avgEnable, k < 12 && (k % 12 < 8 || k % 12 == 11));
      end
      idle_len(4'h5, a);
      idle_len(4'h6, b);
      check(a - b, BASE >> 6);
      idle_len(RATE_FASTEST, a);
      idle_len(RATE_CONTINUOUS, b);
      check(a - b, FAST);
      $display("test_rates done");
   endtask
   task automatic test_limits;
      logic [27:0] rows [8] = '{{8'h00, 10'h158, 8'h12, 2'b00}, {8'h00, 10'h154, 8'h02, 2'b01},
         {8'h00, 10'h12c, 8'h02, 2'b01}, {8'h00, 10'h128, 8'h00, 2'b11},
         {8'h00, 10'h080, 8'h08, 2'b10}, {8'h24, 10'h158, 8'h12, 2'b00},
         {8'h24, 10'h154, 8'h02, 2'b00}, {8'h24, 10'h128, 8'h00, 2'b11}};
      wr(ADDR_RATE_WR, RATE_RESET);
      foreach (rows[i])
      begin
         wr(ADDR_CONFIG1_WR, rows[i][27:20]);
         chanValues[19:10] = rows[i][19:10];
         wait_cycle();
         wait_cycle();
         rdr(ADDR_STATUS1);
         // judge a whole cycle that starts after the clearing read
         while (busy !== 1'b0) @(negedge clock);
         wait_cycle();
         check(rangeExtended, rows[i][22]);
         check(overtemp_out_n, rows[i][1]);
         check(second_overtemp_out_n, rows[i][0]);
         rdr(ADDR_STATUS1);
         check(rd & 8'h7f, rows[i][9:2]);
      end
      rdr(ADDR_HIGH_HI_BASE + 8'h01);
      check(rd, HIGH_LIMIT_RESET);
      wr(ADDR_CONFIG1_WR, CONFIG1_RESET);
      wr(ADDR_HIGH_HI_BASE + 8'h01, HIGH_LIMIT_RESET);
      $display("test_limits done");
   endtask
   task automatic test_single;
      int n;
      logic [1:0] ch;
      chanValues[19:10] = 10'h158;
      for (int s = 3; s >= 0; s--)
      begin
         wr(ADDR_RATE_WR, 8'h08 | 8'(s << 4));
         wait_cycle();
         wait_cycle();
         rdr(ADDR_STATUS1);
         while (busy !== 1'b0) @(negedge clock);
         while (busy !== 1'b1) @(negedge clock);
         ch = convReq.chan;
         for (n = int'(convReq.start); busy === 1'b1; n += int'(convReq.start))
            @(negedge clock);
         check(n, s == 0 ? 3 : 1);
         check(ch, s == 0 ? 0 : s - 1);
         rdr(ADDR_STATUS1);
         check(rd & 8'h18, (s == 0 || s == 2) ? 8'h10 : 8'h00);
      end
      $display("test_single done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         mismatches++;
         complete_run();
      end
   end
   initial
   begin
      repeat (2) @(negedge clock);
      sys_rst = 1'b0;
      test_registers();
      test_rates();
      test_limits();
      test_single();
      complete_run();
   end
endmodule // test_temp_conversion_limit_control
